// ---- core/tim_params.svh ----
`ifndef TIM_PARAMS_SVH
`define TIM_PARAMS_SVH

// Register selects presented on the register port.
`define TIM_SEL_F4_TF     4'h0
`define TIM_SEL_F5_TF     4'h1
`define TIM_SEL_BAR_TF    4'h2
`define TIM_SEL_FLAG_TF   4'h3
`define TIM_SEL_RATE      4'h4
`define TIM_SEL_AF_STS    4'h5
`define TIM_SEL_ANA       4'h6
`define TIM_SEL_SOFT_RST  4'h7

// Test FIFO and analyzer sizes.
`define TIM_TF_DEPTH      16
`define TIM_TF_AW         4
`define TIM_ANA_DEPTH     64
`define TIM_ANA_AW        6

// Rate counter layout.
`define TIM_RATE_W        42
`define TIM_MANT_W        11
`define TIM_EXP_W         5

// Field positions inside test FIFO frames.
`define TIM_EC_PHI_MSB    11
`define TIM_EC_ETA_MSB    6
`define TIM_BAR_Q_MSB     2
`define TIM_BAR_BEND_LSB  4
`define TIM_BAR_BEND_MSB  8
`define TIM_BAR_SECOND    12
`define TIM_BAR_SPECIAL   13
`define TIM_BAR_CROSSING_COUNT_BIT1      12
`define TIM_BAR_CROSSING_COUNT_BIT0      13
`define TIM_BAR_BC0       14
`define TIM_FLAG_TOP      15

// Soft reset action bit that clears the error propagation count.
`define TIM_SOFT_EPC_BIT  0

// Reset values.
`define TIM_EPC_RST       4'h0
`define TIM_DATA_RST      16'h0000

`endif

// ---- core/tim_pkg.sv ----
package tim_pkg;

    // One register access request.
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  sel;
        logic [15:0] wdata;
    } tim_req_t;

    // Commands from the internal fast control bus, one-cycle pulses.
    typedef struct packed {
        logic test_run_command;
        logic level1_reset_command;
        logic event_counter_reset_command;
    } tim_fc_t;

    // Analyzer sample word, laid out as it is stored and read.
    typedef struct packed {
        logic [3:0] accept_phase_samples;
        logic [3:0] strobe_phase_samples;
        logic [5:0] cmd_code;
        logic       event_count_reset_bit;
        logic       crossing_count_reset_bit;
    } tim_ana_smp_t;

    // Injected endcap muon coordinates.
    typedef struct packed {
        logic [11:0] phi;
        logic [6:0]  eta;
    } tim_endcap_t;

    // Injected barrel muon.
    typedef struct packed {
        logic [2:0]  quality;
        logic [4:0]  bend;
        logic        second_muon;
        logic        special_mode;
        logic [11:0] phi;
    } tim_barrel_t;

    // Injected flags, three muons per source, F1 in the low bits.
    typedef struct packed {
        logic [14:0] valid_pattern_flag;
        logic [14:0] sync_error_flag;
    } tim_flags_t;

    // Timing marks of the data path.
    typedef struct packed {
        logic crossing_count_bit0;
        logic crossing_count_bit1;
        logic orbit_mark;
    } tim_timing_t;

    // One-hot alignment write control states.
    typedef enum logic [3:0] {
        af_startup         = 4'b0001,
        af_idle            = 4'b0010,
        first_frame_state  = 4'b0100,
        write_enable_state = 4'b1000
    } tim_alignment_state_bits_t;

endpackage : tim_pkg

// ---- core/tim_test_fifo.sv ----
`timescale 1ns/1ps
`include "tim_params.svh"

module tim_test_fifo (
    input  wire logic        core_clk,  // System clock.
    input  wire logic        rst_n,     // Asynchronous reset, active low.
    input  wire logic        wr_en,     // One frame written by software.
    input  wire logic [15:0] wr_data,   // Frame data.
    input  wire logic        pop,       // Test-run command.
    output logic             rd_valid,  // Entry presented this cycle.
    output logic [31:0]      rd_entry   // Second frame high, first frame low.
);
    logic [31:0]              mem [0:`TIM_TF_DEPTH-1];
    logic [`TIM_TF_AW:0]      wptr_r;
    logic [`TIM_TF_AW:0]      rptr_r;
    logic                     half_r;
    logic [15:0]              frame1_r;
    logic                     empty;
    logic                     full;

    assign empty = (wptr_r == rptr_r);
    assign full  = (wptr_r[`TIM_TF_AW] != rptr_r[`TIM_TF_AW]) &&
                   (wptr_r[`TIM_TF_AW-1:0] == rptr_r[`TIM_TF_AW-1:0]);

    // Frames pair up into one entry; a pair arriving while full is dropped.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            half_r   <= 1'b0;
            frame1_r <= `TIM_DATA_RST;
            wptr_r   <= '0;
        end else if (wr_en) begin
            half_r <= ~half_r;
            if (!half_r) begin
                frame1_r <= wr_data;
            end else if (!full) begin
                wptr_r <= wptr_r + 1'b1;
            end
        end
    end

    // Storage array, written on the second frame.
    always_ff @(posedge core_clk) begin
        if (wr_en && half_r && !full) begin
            mem[wptr_r[`TIM_TF_AW-1:0]] <= {wr_data, frame1_r};
        end
    end

    // Each test-run command with the FIFO not empty presents the oldest entry for one cycle.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rptr_r   <= '0;
            rd_valid <= 1'b0;
            rd_entry <= '0;
        end else begin
            rd_valid <= pop && !empty;
            if (pop && !empty) begin
                rd_entry <= mem[rptr_r[`TIM_TF_AW-1:0]];
                rptr_r   <= rptr_r + 1'b1;
            end
        end
    end

endmodule : tim_test_fifo

// ---- core/tim_top.sv ----
`timescale 1ns/1ps
`include "tim_params.svh"

// Notes on behaviour
// - Write-only test FIFOs, two frames, injected on test run.
// - F4/F5: frame one azimuth, frame two pseudorapidity.
// - Flag FIFO: valid flags, sync errors, timing on top.
// - Flag timing bits injected only when enabled.
// - Barrel: quality, bend, flags; azimuth and timing.
// - Set second-muon flag means previous crossing's second muon.
// - Barrel timing bits injected only when enabled.
// - Rate counter adds pattern bits and nonzero modes.
// - Rate counter clears on level-1 and event resets, counts in run.
// - Rate read as 11-bit mantissa and 5-bit exponent of 42 bits.
// - Four readable one-hot alignment bits, startup lowest.
// - Alignment machine starts up on reset.
// - Level-1 reset, then idle, first frame, write enable.
// - Error count clears on soft-reset bit zero or level-1 reset.
// - Analyzer clears on reset and any analyzer write.
// - Analyzer stores nonzero samples under external control.
// - Analyzer holds at most 64 words.
// - Analyzer read gives one word, or bus error when empty.
// - Word: accept phases, strobe phases, command, two resets.

module tim_top (
    input  wire logic                   core_clk, // System clock.
    input  wire logic                   rst_n, // Reset, active low.
    input  wire tim_pkg::tim_req_t      reg_req, // Register request.
    output logic                        reg_ack, // Access done.
    output logic                        reg_berr, // Access refused.
    output logic [15:0]                 reg_rdata, // Read data.
    input  wire tim_pkg::tim_fc_t       fc_cmd, // Fast commands.
    input  wire logic                   data_taking_run_state, // Run state.
    input  wire logic                   flag_timing_inject_enable, // Flag timing inject.
    input  wire logic                   barrel_timing_inject_enable, // Barrel timing inject.
    input  wire logic                   ext_fast_control, // External control.
    input  wire logic                   pattern_hit, // Valid pattern bit.
    input  wire logic [3:0]             core_mode, // Core decision mode.
    input  wire logic                   link_idle, // Link idle.
    input  wire logic                   link_data, // Link data frame.
    input  wire logic                   af_error, // Alignment error.
    input  wire tim_pkg::tim_ana_smp_t  ana_sample, // Analyzer sample.
    input  wire tim_pkg::tim_timing_t   dp_endcap_timing, // Path endcap timing.
    input  wire tim_pkg::tim_timing_t   dp_barrel_timing, // Path barrel timing.
    output logic                        f4_valid, // F4 strobe.
    output tim_pkg::tim_endcap_t        f4_data, // F4 muon.
    output logic                        f5_valid, // F5 strobe.
    output tim_pkg::tim_endcap_t        f5_data, // F5 muon.
    output logic                        bar_first_valid, // Barrel, this crossing.
    output logic                        bar_second_valid, // Barrel, previous crossing.
    output tim_pkg::tim_barrel_t        bar_data, // Barrel muon.
    output logic                        flag_valid, // Flag strobe.
    output tim_pkg::tim_flags_t         flag_data, // Injected flags.
    output tim_pkg::tim_timing_t        endcap_timing, // Endcap timing out.
    output tim_pkg::tim_timing_t        barrel_timing // Barrel timing out.
);
    import tim_pkg::*;

    logic [3:0]                 tf_wr;
    logic [3:0]                 tf_vld;
    logic [31:0]                tf_ent [0:3];
    logic [`TIM_RATE_W-1:0]     rate_r;
    logic [`TIM_RATE_W-1:0]     rate_inc;
    tim_alignment_state_bits_t              alignment_state_bits_r;
    tim_alignment_state_bits_t              alignment_state_bits_nxt;
    logic [3:0]                 epc_r;
    logic [15:0]                ana_mem [0:`TIM_ANA_DEPTH-1];
    logic [`TIM_ANA_AW:0]       ana_wptr_r;
    logic [`TIM_ANA_AW:0]       ana_rptr_r;
    logic                       ana_empty;
    logic                       ana_full;
    logic                       ana_clr;
    logic                       ana_pop;
    logic                       ana_push;
    logic                       soft_epc;

    // Encodes the count as mantissa times two to the exponent.
    function automatic logic [15:0] rate_float(input logic [`TIM_RATE_W-1:0] cnt);
        logic [`TIM_EXP_W-1:0]  e;
        logic [`TIM_RATE_W-1:0] s;
        logic                   found;
        e     = '1;
        s     = cnt >> (`TIM_EXP_W'(31));
        found = 1'b0;
        for (int i = 0; i < 32; i++) begin
            if (!found && ((cnt >> i) < `TIM_RATE_W'(2048))) begin
                found = 1'b1;
                e     = `TIM_EXP_W'(i);
                s     = cnt >> i;
            end
        end
        return {s[`TIM_MANT_W-1:0], e};
    endfunction : rate_float

    // Register write strobes to the four test FIFOs.
    assign tf_wr[0] = reg_req.wr && (reg_req.sel == `TIM_SEL_F4_TF);
    assign tf_wr[1] = reg_req.wr && (reg_req.sel == `TIM_SEL_F5_TF);
    assign tf_wr[2] = reg_req.wr && (reg_req.sel == `TIM_SEL_BAR_TF);
    assign tf_wr[3] = reg_req.wr && (reg_req.sel == `TIM_SEL_FLAG_TF);

    // One test FIFO per stream, all popped by the test-run command.
    for (genvar g = 0; g < 4; g++) begin : g_tf
        tim_test_fifo u_tf (
            .core_clk (core_clk),
            .rst_n    (rst_n),
            .wr_en    (tf_wr[g]),
            .wr_data  (reg_req.wdata),
            .pop      (fc_cmd.test_run_command),
            .rd_valid (tf_vld[g]),
            .rd_entry (tf_ent[g])
        );
    end

    // Endcap injection registers.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            f4_valid <= 1'b0;
            f5_valid <= 1'b0;
            f4_data  <= '0;
            f5_data  <= '0;
        end else begin
            f4_valid <= tf_vld[0];
            f5_valid <= tf_vld[1];
            if (tf_vld[0]) begin
                f4_data <= {tf_ent[0][`TIM_EC_PHI_MSB:0],
                            tf_ent[0][16+`TIM_EC_ETA_MSB:16]};
            end
            if (tf_vld[1]) begin
                f5_data <= {tf_ent[1][`TIM_EC_PHI_MSB:0],
                            tf_ent[1][16+`TIM_EC_ETA_MSB:16]};
            end
        end
    end

    // Barrel injection, steered by the second-muon flag.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bar_first_valid  <= 1'b0;
            bar_second_valid <= 1'b0;
            bar_data         <= '0;
        end else begin
            bar_first_valid  <= tf_vld[2] && !tf_ent[2][`TIM_BAR_SECOND];
            bar_second_valid <= tf_vld[2] && tf_ent[2][`TIM_BAR_SECOND];
            if (tf_vld[2]) begin
                bar_data.quality      <= tf_ent[2][`TIM_BAR_Q_MSB:0];
                bar_data.bend         <= tf_ent[2][`TIM_BAR_BEND_MSB:`TIM_BAR_BEND_LSB];
                bar_data.second_muon  <= tf_ent[2][`TIM_BAR_SECOND];
                bar_data.special_mode <= tf_ent[2][`TIM_BAR_SPECIAL];
                bar_data.phi          <= tf_ent[2][16+`TIM_EC_PHI_MSB:16];
            end
        end
    end

    // Flag injection; timing bits replace data path timing only when enabled.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_valid    <= 1'b0;
            flag_data     <= '0;
            endcap_timing <= '0;
            barrel_timing <= '0;
        end else begin
            flag_valid    <= tf_vld[3];
            endcap_timing <= dp_endcap_timing;
            barrel_timing <= dp_barrel_timing;
            if (tf_vld[3]) begin
                flag_data <= {tf_ent[3][14:0], tf_ent[3][30:16]};
            end
            if (tf_vld[3] && flag_timing_inject_enable) begin
                endcap_timing.crossing_count_bit0 <= tf_ent[3][`TIM_FLAG_TOP];
                endcap_timing.orbit_mark <= tf_ent[3][16+`TIM_FLAG_TOP];
            end
            if (tf_vld[2] && barrel_timing_inject_enable) begin
                barrel_timing.crossing_count_bit0 <= tf_ent[2][16+`TIM_BAR_CROSSING_COUNT_BIT0];
                barrel_timing.crossing_count_bit1 <= tf_ent[2][16+`TIM_BAR_CROSSING_COUNT_BIT1];
                barrel_timing.orbit_mark <= tf_ent[2][16+`TIM_BAR_BC0];
            end
        end
    end

    // Rate increment this cycle: pattern bit plus nonzero-mode decision.
    assign rate_inc = data_taking_run_state ?
                      (`TIM_RATE_W'(pattern_hit) + `TIM_RATE_W'(core_mode != 4'h0)) :
                      '0;

    // Rate counter; a count in the clearing cycle is kept.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rate_r <= '0;
        end else if (fc_cmd.level1_reset_command || fc_cmd.event_counter_reset_command) begin
            rate_r <= rate_inc;
        end else begin
            rate_r <= rate_r + rate_inc;
        end
    end

    // Alignment write control next state.
    always_comb begin
        alignment_state_bits_nxt = alignment_state_bits_r;
        if (fc_cmd.level1_reset_command) begin
            alignment_state_bits_nxt = af_idle;
        end else begin
            case (alignment_state_bits_r)
                af_startup: alignment_state_bits_nxt = af_startup;
                af_idle: begin
                    if (link_data) alignment_state_bits_nxt = first_frame_state;
                end
                first_frame_state: begin
                    if (link_data) alignment_state_bits_nxt = write_enable_state;
                    else if (link_idle) alignment_state_bits_nxt = af_idle;
                end
                write_enable_state: begin
                    if (!link_data && link_idle) alignment_state_bits_nxt = af_idle;
                end
                default: alignment_state_bits_nxt = af_startup;
            endcase
        end
    end

    // Alignment state register.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            alignment_state_bits_r <= af_startup;
        end else begin
            alignment_state_bits_r <= alignment_state_bits_nxt;
        end
    end

    assign soft_epc = reg_req.wr && (reg_req.sel == `TIM_SEL_SOFT_RST) &&
                      reg_req.wdata[`TIM_SOFT_EPC_BIT];

    // Error propagation counter saturates; an error in the clearing cycle counts.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            epc_r <= `TIM_EPC_RST;
        end else if (soft_epc || fc_cmd.level1_reset_command) begin
            epc_r <= {3'b000, af_error};
        end else if (af_error && (epc_r != 4'hf)) begin
            epc_r <= epc_r + 4'h1;
        end
    end

    // Analyzer queue control.
    assign ana_empty = (ana_wptr_r == ana_rptr_r);
    assign ana_full  = (ana_wptr_r[`TIM_ANA_AW] != ana_rptr_r[`TIM_ANA_AW]) &&
                       (ana_wptr_r[`TIM_ANA_AW-1:0] == ana_rptr_r[`TIM_ANA_AW-1:0]);
    assign ana_clr   = reg_req.wr && (reg_req.sel == `TIM_SEL_ANA);
    assign ana_pop   = reg_req.rd && (reg_req.sel == `TIM_SEL_ANA) && !ana_empty;
    assign ana_push  = ext_fast_control && (ana_sample != '0) &&
                       (ana_clr || !ana_full);

    // Analyzer pointers; a sample in the clearing cycle becomes the first word.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ana_wptr_r <= '0;
            ana_rptr_r <= '0;
        end else if (ana_clr) begin
            ana_rptr_r <= '0;
            ana_wptr_r <= {{`TIM_ANA_AW{1'b0}}, ana_push};
        end else begin
            if (ana_push) ana_wptr_r <= ana_wptr_r + 1'b1;
            if (ana_pop) ana_rptr_r <= ana_rptr_r + 1'b1;
        end
    end

    // Analyzer storage.
    always_ff @(posedge core_clk) begin
        if (ana_push) begin
            ana_mem[ana_clr ? '0 : ana_wptr_r[`TIM_ANA_AW-1:0]] <= ana_sample;
        end
    end

    // Register answers, one cycle after the request.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_ack   <= 1'b0;
            reg_berr  <= 1'b0;
            reg_rdata <= `TIM_DATA_RST;
        end else begin
            reg_ack   <= 1'b0;
            reg_berr  <= 1'b0;
            if (reg_req.wr) begin
                if (reg_req.sel <= `TIM_SEL_FLAG_TF || reg_req.sel == `TIM_SEL_ANA ||
                    reg_req.sel == `TIM_SEL_SOFT_RST) begin
                    reg_ack <= 1'b1;
                end else begin
                    reg_berr <= 1'b1;
                end
            end else if (reg_req.rd) begin
                case (reg_req.sel)
                    `TIM_SEL_RATE: begin
                        reg_ack   <= 1'b1;
                        reg_rdata <= rate_float(rate_r);
                    end
                    `TIM_SEL_AF_STS: begin
                        reg_ack   <= 1'b1;
                        reg_rdata <= {4'h0, epc_r, 4'h0, alignment_state_bits_r};
                    end
                    `TIM_SEL_ANA: begin
                        if (ana_empty) begin
                            reg_berr <= 1'b1;
                        end else begin
                            reg_ack   <= 1'b1;
                            reg_rdata <= ana_mem[ana_rptr_r[`TIM_ANA_AW-1:0]];
                        end
                    end
                    default: reg_berr <= 1'b1;
                endcase
            end
        end
    end

endmodule : tim_top

// ---- test/tim_top_monitor.sv ----
`timescale 1ns/1ps

module tim_top_monitor (
    input wire logic                core_clk, // System clock.
    input wire logic                rst_n, // Reset, active low.
    input wire tim_pkg::tim_req_t   reg_req, // Register request.
    input wire logic                reg_ack, // Access done.
    input wire logic                reg_berr, // Access refused.
    input wire logic [15:0]         reg_rdata, // Read data.
    input wire tim_pkg::tim_fc_t    fc_cmd, // Fast commands.
    input wire logic                flag_timing_inject_enable, // Flag timing inject.
    input wire logic                barrel_timing_inject_enable, // Barrel timing inject.
    input wire logic                ext_fast_control, // External control.
    input wire tim_pkg::tim_timing_t dp_endcap_timing, // Path endcap timing.
    input wire tim_pkg::tim_timing_t dp_barrel_timing, // Path barrel timing.
    input wire logic                f4_valid, // F4 strobe.
    input wire logic                bar_first_valid, // Barrel this crossing.
    input wire logic                bar_second_valid, // Barrel previous.
    input wire tim_pkg::tim_barrel_t bar_data, // Barrel muon.
    input wire tim_pkg::tim_timing_t endcap_timing, // Endcap timing out.
    input wire tim_pkg::tim_timing_t barrel_timing // Barrel timing out.
);
    // System clock; checks rest in reset.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_ack_has_req: assert property (reg_ack |-> $past(reg_req.wr) || $past(reg_req.rd))
        else $error("answer without a request");
    a_wo_read_berr: assert property (reg_req.rd && !reg_req.wr && reg_req.sel < 4'h4
        |=> reg_berr && !reg_ack) else $error("test fifo read not refused");
    a_inject_lat: assert property (f4_valid |-> $past(fc_cmd.test_run_command, 2))
        else $error("injection without test run");
    a_second_slot: assert property (bar_second_valid |-> bar_data.second_muon && !bar_first_valid)
        else $error("second muon slot wrong");
    a_flag_keep: assert property ($past(rst_n) && !flag_timing_inject_enable
        && !$past(flag_timing_inject_enable) |-> endcap_timing == $past(dp_endcap_timing))
        else $error("endcap timing not kept");
    a_bar_keep: assert property ($past(rst_n) && !barrel_timing_inject_enable
        && !$past(barrel_timing_inject_enable) |-> barrel_timing == $past(dp_barrel_timing))
        else $error("barrel timing not kept");
    a_rate_norm: assert property (reg_ack && $past(reg_req.sel) == 4'h4 && !$past(reg_req.wr)
        |-> reg_rdata[4:0] == 5'h00 || reg_rdata[15]) else $error("rate not normalised");
    a_af_onehot: assert property (reg_ack && $past(reg_req.sel) == 4'h5 && !$past(reg_req.wr)
        |-> $onehot(reg_rdata[3:0]) && reg_rdata[15:12] == 4'h0 && reg_rdata[7:4] == 4'h0)
        else $error("alignment status malformed");
    a_ana_cleared: assert property (reg_req.wr && reg_req.sel == 4'h6 && !ext_fast_control
        ##1 !reg_req.wr && !ext_fast_control ##1 reg_req.rd && !reg_req.wr
        && reg_req.sel == 4'h6 && !ext_fast_control |=> reg_berr) else $error("analyzer not cleared");

    // Main scenarios seen.
    c_inject: cover property (f4_valid);
    c_second: cover property (bar_second_valid);
    c_berr: cover property (reg_berr);
endmodule : tim_top_monitor

// ---- test/tim_top_tb.sv ----
`timescale 1ns/1ps

module tim_top_tb;
    import tim_pkg::*;
    logic core_clk, rst_n, run, fti, bti, ext, hit, l_idle, l_data, af_err, a, b;
    logic f4v, f5v, bfv, bsv, flv, ack, berr;
    logic [3:0] mode;
    logic [15:0] q, rdata;
    logic [4:0] rf [3] = '{5'h00, 5'h15, 5'h09};
    tim_req_t req;
    tim_fc_t fc;
    tim_ana_smp_t smp;
    tim_timing_t dpe, dpb, et, bt;
    tim_endcap_t f4d, f5d;
    tim_barrel_t bd;
    tim_flags_t fd;
    tim_ana_smp_t aq [$];
    int n_fail = 0, check_count = 0, seed = 32'h0468, i, k, n_exp;
    longint cnt;

    tim_top u_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_req(req), .reg_ack(ack),
        .reg_berr(berr), .reg_rdata(rdata), .fc_cmd(fc), .data_taking_run_state(run),
        .flag_timing_inject_enable(fti), .barrel_timing_inject_enable(bti),
        .ext_fast_control(ext), .pattern_hit(hit), .core_mode(mode), .link_idle(l_idle),
        .link_data(l_data), .af_error(af_err), .ana_sample(smp), .dp_endcap_timing(dpe),
        .dp_barrel_timing(dpb), .f4_valid(f4v), .f4_data(f4d), .f5_valid(f5v), .f5_data(f5d),
        .bar_first_valid(bfv), .bar_second_valid(bsv), .bar_data(bd), .flag_valid(flv),
        .flag_data(fd), .endcap_timing(et), .barrel_timing(bt));
    tim_vme_master u_vme (.core_clk(core_clk), .reg_ack(ack), .reg_berr(berr),
        .reg_rdata(rdata), .reg_req(req));

    // Free-running 125 MHz clock.
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", nm, e, g);
            n_fail++;
        end
    endtask : chk

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finish_test

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc

    task automatic rw(input logic w, input logic [3:0] s, input logic [15:0] d);
        u_vme.acc(w, s, d, a, b, q);
    endtask : rw

    // Expected rate readout: smallest shift that fits the mantissa.
    function automatic logic [15:0] fmt(input longint c);
        int e = 0;
        while ((c >> e) > 2047) e++;
        return {11'(c >> e), e[4:0]};
    endfunction : fmt

    // Main sequence.
    initial begin
        {rst_n, run, fti, bti, ext, hit, l_idle, l_data, af_err} = '0;
        mode = '0; fc = '0; smp = '0; dpe = 3'b010; dpb = 3'b001; cnt = 0;
        cyc(20);
        rst_n = 1'b1;
        rw(0, 4'h5, 0); chk("af_reset", 17'h10001, {a, q});
        fc.level1_reset_command = 1'b1; l_idle = 1'b1; cyc(1); fc = '0; l_idle = 1'b0;
        rw(0, 4'h5, 0); chk("af_idle", 17'h10002, {a, q});
        for (k = 0; k < 2; k++) begin
            l_data = 1'b1; af_err = 1'b1; cyc(1); l_data = 1'b0; af_err = 1'b0;
            rw(0, 4'h5, 0); chk("af_frame", 17'h10000 | ((k + 1) << 8) | (4 << k), {a, q});
        end
        rw(1, 4'h7, 16'h0001); rw(0, 4'h5, 0); chk("epc_clr", 17'h10008, {a, q});
        // Rate counter in run.
        run = 1'b1;
        for (i = 0; i < 1500; i++) begin
            hit = $random(seed); mode = $random(seed); cnt += hit + (mode != 0); cyc(1);
        end
        run = 1'b0; cyc(3); hit = 1'b0; mode = '0;
        rw(0, 4'h4, 0); chk("rate", {1'b1, fmt(cnt)}, {a, q});
        fc.event_counter_reset_command = 1'b1; cyc(1); fc = '0;
        rw(0, 4'h4, 0); chk("rate_clr", 17'h10000, {a, q});
        // Injection, with and without timing inject.
        for (k = 0; k < 2; k++) begin
            fti = !k; bti = !k;
            for (i = 0; i < 2; i++) begin
                rw(1, i, 16'hf123 + i); rw(1, i, 16'hf0a5 + i);
            end
            rw(1, 4'h2, 16'h1153 ^ (k * 16'h3000)); rw(1, 4'h2, 16'h6abc);
            rw(1, 4'h3, 16'h9234); rw(1, 4'h3, 16'h8f0f);
            cyc(3); fc.test_run_command = 1'b1; cyc(1); fc = '0;
            for (i = 0; i < 6 && f4v !== 1'b1; i++) cyc(1);
            if (i == 6) begin
                n_fail++;
                finish_test();
            end
            chk("strobes", {3'b111, !k[0], k[0]}, {f4v, f5v, flv, bsv, bfv});
            chk("f4", {12'h123, 7'h25}, f4d);
            chk("f5", {12'h124, 7'h26}, f5d);
            chk("bar", {3'h3, 5'h15, !k[0], k[0], 12'habc}, bd);
            chk("flags", {15'h1234, 15'h0f0f}, fd);
            chk("et", k ? 3'b010 : 3'b111, et);
            chk("bt", k ? 3'b001 : 3'b101, bt);
        end
        for (k = 0; k < 3; k++) begin
            rw(rf[k][4], rf[k][3:0], 16'h0001); chk("refuse", 2'b01, {a, b});
        end
        // Analyzer capture, drain and clear.
        rw(1, 4'h6, 16'h5a5a);
        for (i = 0; i < 100; i++) begin
            ext = (i >= 8); smp = (i % 4 == 0) ? 16'h0000 : 16'($random(seed));
            if (ext && smp != 0 && aq.size() < 64) aq.push_back(smp);
            cyc(1);
        end
        ext = 1'b0; smp = '0; n_exp = aq.size();
        for (i = 0; i < 70; i++) begin
            rw(0, 4'h6, 0);
            if (b) break;
            chk("ana_word", {1'b1, aq.pop_front()}, {a, q});
        end
        chk("ana_count", n_exp, i);
        ext = 1'b1; smp = 16'h0f0c; cyc(3); ext = 1'b0; smp = '0;
        rw(1, 4'h6, 16'h0000); rw(0, 4'h6, 0); chk("ana_clr", 2'b01, {a, b});
        finish_test();
    end
endmodule : tim_top_tb

bind tim_top tim_top_monitor u_mon (.core_clk, .rst_n, .reg_req, .reg_ack, .reg_berr,
    .reg_rdata, .fc_cmd, .flag_timing_inject_enable, .barrel_timing_inject_enable,
    .ext_fast_control, .dp_endcap_timing, .dp_barrel_timing, .f4_valid, .bar_first_valid,
    .bar_second_valid, .bar_data, .endcap_timing, .barrel_timing);

// ---- test/tim_vme_master.sv ----
`timescale 1ns/1ps

module tim_vme_master (
    input wire logic          core_clk,  // System clock.
    input wire logic          reg_ack,   // Access done.
    input wire logic          reg_berr,  // Access refused.
    input wire logic [15:0]   reg_rdata, // Read data.
    output tim_pkg::tim_req_t reg_req    // Request to the block.
);
    import tim_pkg::*;

    // Bus idle until the first access.
    initial reg_req = '0;

    // One access: request for one edge, idle edge before it.
    task automatic acc(input logic w, input logic [3:0] s, input logic [15:0] d,
                       output logic ak, output logic be, output logic [15:0] q);
        @(posedge core_clk);
        #1 reg_req = '{w, !w, s, d};
        @(posedge core_clk);
        #1 reg_req = '0;
        ak = reg_ack;
        be = reg_berr;
        q = reg_rdata;
    endtask : acc
endmodule : tim_vme_master
